/* File: cmds_chk.sv */
// port assertions for the clock monitor and oscillator stepper
`timescale 1ns/10ps
module cmds_chk
  import cmds_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // bus and detectors
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic        internal_inactive,
  input wire logic        external_inactive,
  // loop filter
  input wire logic        corr_valid,
  input wire logic        corr_up,
  input wire logic        err_large,
  input wire logic        ring_tick,
  // watched outputs
  input wire logic        osc_sel_external,
  input wire logic        monitor_irq,
  input wire logic [7:0]  stage_code,
  input wire logic [3:0]  divider_code,
  input wire logic [5:0]  ring_stages,
  input wire logic [15:0] cycle_delays,
  input wire logic        long_cycle
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // a write may legally move the source or enable the interrupt too
  wire logic bus_wr = wb_cyc_i & wb_stb_i & wb_we_i;

  property p_fail_irq; $rose(monitor_irq) |-> $past(internal_inactive | external_inactive | bus_wr); endproperty
  a_fail_irq: assert property (p_fail_irq) else $error("monitor interrupt rose without cause");
  property p_sel; $rose(osc_sel_external) |-> $past(internal_inactive | bus_wr); endproperty
  a_sel: assert property (p_sel) else $error("external source chosen without cause");
  property p_div_max; divider_code <= 4'h9; endproperty
  a_div_max: assert property (p_div_max) else $error("divider code above nine");
  property p_hold; !corr_valid |=> $stable(stage_code) && $stable(divider_code); endproperty
  a_hold: assert property (p_hold) else $error("codes moved without correction");
  property p_carry;
    corr_valid & corr_up & err_large & (divider_code < 4'h9) & (stage_code > 8'hdf) |=>
      divider_code == $past(divider_code) + 4'h1;
  endproperty
  a_carry: assert property (p_carry) else $error("carry did not step divider");
  property p_coarse; corr_valid & corr_up & err_large & (stage_code < 8'he0) |=> stage_code == $past(stage_code) + 8'h20;
  endproperty
  a_coarse: assert property (p_coarse) else $error("coarse step wrong");
  property p_fine; corr_valid & !corr_up & !err_large & (stage_code != 8'h00) |=> stage_code == $past(stage_code) - 8'h01;
  endproperty
  a_fine: assert property (p_fine) else $error("fine step wrong");
  property p_cycle; ring_tick |=> cycle_delays == ({10'h000, ring_stages} << $past(divider_code)); endproperty
  a_cycle: assert property (p_cycle) else $error("cycle delay not ring shifted by divider");
  property p_ring; ring_tick |=> long_cycle || ring_stages == 6'h11 + {$past(stage_code[7:5]), 1'b0}; endproperty
  a_ring: assert property (p_ring) else $error("nominal ring length wrong");
  property p_nolong; ring_tick & (stage_code[4:0] == 5'h00) |=> !long_cycle; endproperty
  a_nolong: assert property (p_nolong) else $error("long cycle with zero fraction");

  c_fail: cover property ($rose(monitor_irq));
  c_sat: cover property (divider_code == 4'h9 && stage_code == 8'hff);
  c_long: cover property (long_cycle);
endmodule

bind cmds_top cmds_chk cmds_chk_inst (
  .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .internal_inactive(internal_inactive), .external_inactive(external_inactive),
  .corr_valid(corr_valid), .corr_up(corr_up), .err_large(err_large), .ring_tick(ring_tick),
  .osc_sel_external(osc_sel_external), .monitor_irq(monitor_irq), .stage_code(stage_code),
  .divider_code(divider_code), .ring_stages(ring_stages), .cycle_delays(cycle_delays), .long_cycle(long_cycle)
);

/* File: cmds_dco_step.sv */
// stage and divider code stepper driven by loop filter corrections
`timescale 1ns/10ps
module cmds_dco_step
  import cmds_pkg::*;
#(
  parameter logic [CMDS_STAGE_W-1:0] STAGE_INIT = CMDS_STAGE_RESET,
  parameter logic [CMDS_DIV_W-1:0]   DIV_INIT   = CMDS_DIV_RESET
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // correction request
  input  wire logic                    corr_valid,
  input  wire logic                    corr_up,
  input  wire logic                    err_large,
  // codes and events
  output logic [CMDS_STAGE_W-1:0]      stage_code,
  output logic [CMDS_DIV_W-1:0]        divider_code,
  output logic                         div_step,
  output logic                         saturated
);

  typedef struct packed {
    logic [CMDS_STAGE_W-1:0] stage;
    logic [CMDS_DIV_W-1:0]   div;
    logic                    step;
    logic                    sat;
  } cmds_step_st_t;

  cmds_step_st_t st_r;
  cmds_step_st_t st_nxt;

  always_comb begin
    logic [CMDS_STAGE_W-1:0] step;
    logic [CMDS_STAGE_W:0]   sum;
    st_nxt      = st_r;
    st_nxt.step = 1'b0;
    st_nxt.sat  = 1'b0;
    step        = err_large ? CMDS_STEP_COARSE : CMDS_STEP_FINE;
    sum         = '0;
    if (corr_valid) begin
      if (corr_up) begin
        sum = {1'b0, st_r.stage} + {1'b0, step};
      end else begin
        sum = {1'b0, st_r.stage} - {1'b0, step};
      end
      // the divider only moves on carry or borrow out of the stage code
      if (!sum[CMDS_STAGE_W]) begin
        st_nxt.stage = sum[CMDS_STAGE_W-1:0];
      end else if (corr_up && st_r.div < CMDS_DIV_MAX) begin
        st_nxt.stage = sum[CMDS_STAGE_W-1:0];
        st_nxt.div   = st_r.div + 4'h1;
        st_nxt.step  = 1'b1;
      end else if (!corr_up && st_r.div > CMDS_DIV_MIN) begin
        st_nxt.stage = sum[CMDS_STAGE_W-1:0];
        st_nxt.div   = st_r.div - 4'h1;
        st_nxt.step  = 1'b1;
      end else begin
        // at either end of the range the period stops rather than wrapping
        st_nxt.stage = corr_up ? CMDS_STAGE_FULL : CMDS_STAGE_EMPTY;
        st_nxt.sat   = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '{stage: STAGE_INIT, div: DIV_INIT, step: 1'b0, sat: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign stage_code   = st_r.stage;
  assign divider_code = st_r.div;
  assign div_step     = st_r.step;
  assign saturated    = st_r.sat;

endmodule

/* File: cmds_fine_adj.sv */
// ring length, fine-adjust dithering and binary divider: period of each ring cycle
`timescale 1ns/10ps
module cmds_fine_adj
  import cmds_pkg::*;
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // one pulse per modelled ring cycle
  input  wire logic                    ring_tick,
  // codes
  input  wire logic [CMDS_STAGE_W-1:0] stage_code,
  input  wire logic [CMDS_DIV_W-1:0]   divider_code,
  // period of the current cycle
  output logic [CMDS_RING_W-1:0]       ring_stages,
  output logic [CMDS_DELAY_W-1:0]      cycle_delays,
  output logic                         long_cycle
);

  typedef struct packed {
    logic [CMDS_FRAC_W-1:0]  acc;
    logic [CMDS_RING_W-1:0]  ring;
    logic [CMDS_DELAY_W-1:0] delays;
    logic                    long_c;
  } cmds_fine_st_t;

  cmds_fine_st_t st_r;
  cmds_fine_st_t st_nxt;

  always_comb begin
    logic [2:0]              coarse;
    logic [CMDS_FRAC_W-1:0]  frac;
    logic [CMDS_FRAC_W:0]    acc_sum;
    logic [CMDS_RING_W-1:0]  nominal;
    logic [CMDS_RING_W-1:0]  stages;
    logic [CMDS_DIV_W-1:0]   div_eff;
    coarse  = stage_code[CMDS_STAGE_W-1:CMDS_FRAC_W];
    frac    = stage_code[CMDS_FRAC_W-1:0];
    st_nxt  = st_r;
    acc_sum = '0;
    nominal = CMDS_RING_BASE + CMDS_RING_INC * {3'h0, coarse};
    stages  = nominal;
    div_eff = (divider_code > CMDS_DIV_MAX) ? CMDS_DIV_MAX : divider_code;
    if (ring_tick) begin
      // accumulator spreads exactly frac long cycles over every 32
      acc_sum       = {1'b0, st_r.acc} + {1'b0, frac};
      st_nxt.acc    = acc_sum[CMDS_FRAC_W-1:0];
      st_nxt.long_c = acc_sum[CMDS_FRAC_W];
      if (acc_sum[CMDS_FRAC_W]) begin
        // the top ring setting borrows the shortest ring run at half speed
        stages = (coarse == CMDS_RING_TOP_SEL) ? CMDS_RING_TOP_ALT : nominal + CMDS_RING_INC;
      end
      st_nxt.ring   = stages;
      st_nxt.delays = {{(CMDS_DELAY_W-CMDS_RING_W){1'b0}}, stages} << div_eff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '{acc: '0, ring: CMDS_RING_BASE, delays: {{(CMDS_DELAY_W-CMDS_RING_W){1'b0}}, CMDS_RING_BASE},
                long_c: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ring_stages  = st_r.ring;
  assign cycle_delays = st_r.delays;
  assign long_cycle   = st_r.long_c;

endmodule

/* File: cmds_pkg.sv */
// constants, register map and field layout of the clock monitor and oscillator stepping block
package cmds_pkg;

  // register byte addresses, one aligned word each
  localparam logic [7:0] CMDS_ADDR_CTRL     = 8'h00;
  localparam logic [7:0] CMDS_ADDR_DCO      = 8'h04;
  localparam logic [7:0] CMDS_ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] CMDS_ADDR_IRQ_CLR  = 8'h0c;
  localparam logic [7:0] CMDS_ADDR_IRQ_EN   = 8'h10;

  // control register bit positions
  localparam int unsigned CMDS_CTRL_INT_ON  = 0;
  localparam int unsigned CMDS_CTRL_INT_STB = 1;
  localparam int unsigned CMDS_CTRL_EXT_ON  = 2;
  localparam int unsigned CMDS_CTRL_EXT_STB = 3;
  localparam int unsigned CMDS_CTRL_CS      = 4;
  localparam int unsigned CMDS_CTRL_MON     = 5;
  localparam int unsigned CMDS_CTRL_FAIL    = 6;
  localparam int unsigned CMDS_CTRL_MIE     = 7;
  localparam int unsigned CMDS_CTRL_W       = 8;

  // oscillator status register layout
  localparam int unsigned CMDS_DCO_STAGE_LSB = 0;
  localparam int unsigned CMDS_DCO_DIV_LSB   = 8;
  localparam int unsigned CMDS_DCO_SLOW      = 12;
  localparam int unsigned CMDS_DCO_COARSE    = 13;

  // interrupt status bits
  localparam int unsigned CMDS_IRQ_FAIL = 0;
  localparam int unsigned CMDS_IRQ_DIV  = 1;
  localparam int unsigned CMDS_IRQ_SAT  = 2;
  localparam int unsigned CMDS_IRQ_W    = 3;

  // oscillator code widths and limits
  localparam int unsigned CMDS_STAGE_W = 8;
  localparam int unsigned CMDS_DIV_W   = 4;
  localparam int unsigned CMDS_FRAC_W  = 5;
  localparam int unsigned CMDS_RING_W  = 6;
  localparam int unsigned CMDS_DELAY_W = 16;

  localparam logic [CMDS_DIV_W-1:0]   CMDS_DIV_MAX     = 4'h9;
  localparam logic [CMDS_DIV_W-1:0]   CMDS_DIV_MIN     = 4'h0;
  localparam logic [CMDS_STAGE_W-1:0] CMDS_STAGE_RESET = 8'h00;
  localparam logic [CMDS_DIV_W-1:0]   CMDS_DIV_RESET   = 4'h0;
  localparam logic [CMDS_STAGE_W-1:0] CMDS_STEP_COARSE = 8'h20;
  localparam logic [CMDS_STAGE_W-1:0] CMDS_STEP_FINE   = 8'h01;
  localparam logic [CMDS_STAGE_W-1:0] CMDS_STAGE_FULL  = 8'hff;
  localparam logic [CMDS_STAGE_W-1:0] CMDS_STAGE_EMPTY = 8'h00;

  // ring length in stage delays
  localparam logic [CMDS_RING_W-1:0] CMDS_RING_BASE    = 6'h11;
  localparam logic [CMDS_RING_W-1:0] CMDS_RING_INC     = 6'h02;
  localparam logic [CMDS_RING_W-1:0] CMDS_RING_TOP_ALT = 6'h22;
  localparam logic [2:0]             CMDS_RING_TOP_SEL = 3'h7;

  // control register after reset: internal generator on, internal clock selected
  localparam logic [CMDS_CTRL_W-1:0] CMDS_CTRL_RESET = 8'h01;

endpackage

/* File: cmds_top.sv */
// clock monitor control, source failover and digital oscillator stepping with a wishbone register file
`timescale 1ns/10ps
module cmds_top
  import cmds_pkg::*;
#(
  parameter logic [CMDS_STAGE_W-1:0] STAGE_INIT = CMDS_STAGE_RESET,
  parameter logic [CMDS_DIV_W-1:0]   DIV_INIT   = CMDS_DIV_RESET
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // wishbone slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [7:0]               wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  // activity detectors and options
  input  wire logic                     internal_inactive,
  input  wire logic                     external_inactive,
  input  wire logic                     internal_clk_stable,
  input  wire logic                     external_clk_stable,
  input  wire logic                     slow_external_option,
  // loop filter corrections
  input  wire logic                     corr_valid,
  input  wire logic                     corr_up,
  input  wire logic                     err_large,
  input  wire logic                     ring_tick,
  // clock generator controls
  output logic                          internal_gen_on,
  output logic                          external_gen_on,
  output logic                          osc_sel_external,
  output logic                          timebase_sel_external,
  // interrupts
  output logic                          monitor_irq,
  output logic                          irq,
  // oscillator codes and period
  output logic [CMDS_STAGE_W-1:0]       stage_code,
  output logic [CMDS_DIV_W-1:0]         divider_code,
  output logic [CMDS_RING_W-1:0]        ring_stages,
  output logic [CMDS_DELAY_W-1:0]       cycle_delays,
  output logic                          long_cycle
);

  typedef struct packed {
    logic                  ack;
    logic [31:0]           rdata;
    logic                  int_on;
    logic                  ext_on;
    logic                  cs;
    logic                  tb_ext;
    logic                  mon;
    logic                  fail;
    logic                  mie;
    logic                  fail_armed;
    logic [CMDS_IRQ_W-1:0] stat;
    logic [CMDS_IRQ_W-1:0] en;
    logic                  mon_irq;
    logic                  irq;
  } cmds_st_t;

  cmds_st_t st_r;
  cmds_st_t st_nxt;

  logic                    div_step;
  logic                    saturated;
  logic [CMDS_STAGE_W-1:0] stage_w;
  logic [CMDS_DIV_W-1:0]   div_w;

  cmds_dco_step #(
    .STAGE_INIT   (STAGE_INIT),
    .DIV_INIT     (DIV_INIT)
  ) u_step (
    .clk          (clk),
    .rst          (rst),
    .corr_valid   (corr_valid),
    .corr_up      (corr_up),
    .err_large    (err_large),
    .stage_code   (stage_w),
    .divider_code (div_w),
    .div_step     (div_step),
    .saturated    (saturated)
  );

  cmds_fine_adj u_fine (
    .clk          (clk),
    .rst          (rst),
    .ring_tick    (ring_tick),
    .stage_code   (stage_w),
    .divider_code (div_w),
    .ring_stages  (ring_stages),
    .cycle_delays (cycle_delays),
    .long_cycle   (long_cycle)
  );

  always_comb begin
    logic                   req;
    logic                   wr;
    logic                   rd;
    logic                   lane0;
    logic [CMDS_CTRL_W-1:0] ctrl_rd;
    logic [CMDS_CTRL_W-1:0] wd;
    logic [CMDS_IRQ_W-1:0]  events;
    logic                   mon_ok;
    logic                   int_dead;
    logic                   ext_dead;
    st_nxt  = st_r;
    req     = wb_cyc_i && wb_stb_i && !st_r.ack;
    wr      = req && wb_we_i;
    rd      = req && !wb_we_i;
    lane0   = wb_sel_i[0];
    wd      = wb_dat_i[CMDS_CTRL_W-1:0];
    events  = '0;
    int_dead = st_r.mon && internal_inactive;
    ext_dead = st_r.mon && external_inactive;
    ctrl_rd = '0;
    ctrl_rd[CMDS_CTRL_INT_ON]  = st_r.int_on;
    ctrl_rd[CMDS_CTRL_INT_STB] = internal_clk_stable;
    ctrl_rd[CMDS_CTRL_EXT_ON]  = st_r.ext_on;
    ctrl_rd[CMDS_CTRL_EXT_STB] = external_clk_stable;
    ctrl_rd[CMDS_CTRL_CS]      = st_r.cs;
    ctrl_rd[CMDS_CTRL_MON]     = st_r.mon;
    ctrl_rd[CMDS_CTRL_FAIL]    = st_r.fail;
    ctrl_rd[CMDS_CTRL_MIE]     = st_r.mie;
    mon_ok  = st_r.int_on && st_r.ext_on && internal_clk_stable && external_clk_stable;

    // bus: one wait state, ack drops the cycle after it was given
    st_nxt.ack   = req;
    st_nxt.rdata = '0;
    if (rd) begin
      case (wb_adr_i)
        CMDS_ADDR_CTRL: begin
          st_nxt.rdata[CMDS_CTRL_W-1:0] = ctrl_rd;
          if (st_r.fail) begin
            st_nxt.fail_armed = 1'b1;
          end
        end
        CMDS_ADDR_DCO: begin
          st_nxt.rdata[CMDS_DCO_STAGE_LSB +: CMDS_STAGE_W] = stage_w;
          st_nxt.rdata[CMDS_DCO_DIV_LSB +: CMDS_DIV_W]     = div_w;
          st_nxt.rdata[CMDS_DCO_SLOW]                      = slow_external_option;
          st_nxt.rdata[CMDS_DCO_COARSE]                    = err_large;
        end
        CMDS_ADDR_IRQ_STAT: begin
          st_nxt.rdata[CMDS_IRQ_W-1:0] = st_r.stat;
        end
        CMDS_ADDR_IRQ_EN: begin
          st_nxt.rdata[CMDS_IRQ_W-1:0] = st_r.en;
        end
        default: begin
          st_nxt.rdata = '0;
        end
      endcase
    end

    if (wr && lane0) begin
      case (wb_adr_i)
        CMDS_ADDR_CTRL: begin
          st_nxt.ext_on = wd[CMDS_CTRL_EXT_ON];
          // the generator feeding the source selected before the write cannot be switched off
          st_nxt.int_on = wd[CMDS_CTRL_INT_ON] || !st_r.cs;
          st_nxt.ext_on = wd[CMDS_CTRL_EXT_ON] || st_r.cs;
          // source switch only with both generators on and the target stable
          if (st_r.int_on && st_r.ext_on) begin
            if (wd[CMDS_CTRL_CS] && external_clk_stable) begin
              st_nxt.cs = 1'b1;
            end else if (!wd[CMDS_CTRL_CS] && internal_clk_stable) begin
              st_nxt.cs = 1'b0;
            end
          end
          if (!wd[CMDS_CTRL_MON]) begin
            st_nxt.mon = 1'b0;
          end else if (mon_ok) begin
            st_nxt.mon = 1'b1;
          end
          // judged on the old monitor enable, so one repeated write walks the order
          if (!wd[CMDS_CTRL_MIE]) begin
            st_nxt.mie = 1'b0;
          end else if (st_r.mon) begin
            st_nxt.mie = 1'b1;
          end
          if (!wd[CMDS_CTRL_FAIL] && st_r.fail_armed) begin
            st_nxt.fail       = 1'b0;
            st_nxt.fail_armed = 1'b0;
          end
        end
        CMDS_ADDR_IRQ_CLR: begin
          st_nxt.stat = st_r.stat & ~wd[CMDS_IRQ_W-1:0];
        end
        CMDS_ADDR_IRQ_EN: begin
          st_nxt.en = wd[CMDS_IRQ_W-1:0];
        end
        default: begin
          st_nxt.en = st_nxt.en;
        end
      endcase
    end

    // hardware after the bus: failover and flag setting win over software
    if (int_dead || ext_dead) begin
      st_nxt.fail = 1'b1;
      events[CMDS_IRQ_FAIL] = !st_r.fail;
      // a fresh set needs a fresh read before a clear is accepted
      if (!st_r.fail) begin
        st_nxt.fail_armed = 1'b0;
      end
    end
    if (int_dead && !ext_dead) begin
      st_nxt.cs = 1'b1;
    end else if (ext_dead && !int_dead) begin
      st_nxt.cs = 1'b0;
    end
    // timebase follows the external generator unless a dead clock forces it
    if (int_dead && !ext_dead) begin
      st_nxt.tb_ext = 1'b1;
    end else if (ext_dead && !int_dead) begin
      st_nxt.tb_ext = 1'b0;
    end else begin
      st_nxt.tb_ext = st_nxt.ext_on;
    end

    events[CMDS_IRQ_DIV] = div_step;
    events[CMDS_IRQ_SAT] = saturated;
    st_nxt.stat    = st_nxt.stat | events;
    st_nxt.irq     = |(st_nxt.stat & st_nxt.en);
    st_nxt.mon_irq = st_nxt.fail && st_nxt.mie;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r            <= '0;
      st_r.int_on     <= CMDS_CTRL_RESET[CMDS_CTRL_INT_ON];
      st_r.ext_on     <= CMDS_CTRL_RESET[CMDS_CTRL_EXT_ON];
      st_r.cs         <= CMDS_CTRL_RESET[CMDS_CTRL_CS];
      st_r.mon        <= CMDS_CTRL_RESET[CMDS_CTRL_MON];
      st_r.mie        <= CMDS_CTRL_RESET[CMDS_CTRL_MIE];
      st_r.fail       <= CMDS_CTRL_RESET[CMDS_CTRL_FAIL];
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_ack_o              = st_r.ack;
  assign wb_dat_o              = st_r.rdata;
  assign internal_gen_on       = st_r.int_on;
  assign external_gen_on       = st_r.ext_on;
  assign osc_sel_external      = st_r.cs;
  assign timebase_sel_external = st_r.tb_ext;
  assign monitor_irq           = st_r.mon_irq;
  assign irq                   = st_r.irq;
  assign stage_code            = stage_w;
  assign divider_code          = div_w;

endmodule

/* File: tb_top.sv */
// directed bench for the clock monitor and oscillator stepper
`timescale 1ns/10ps
module tb_top;
  import cmds_pkg::*;
  logic        clk, rst, cyc, stb, we, ii, ei, ist, est, slow, cv, cu, el, rt;
  logic        ack, ion, eon, osel, tsel, mirq, irq, lng;
  logic [3:0]  sel, dv;
  logic [5:0]  rs;
  logic [7:0]  adr, stg;
  logic [15:0] cd;
  logic [31:0] dat, dato, q;
  int          fail_count, comparisons;

  cmds_top cmds_top_inst (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack),
    .internal_inactive(ii), .external_inactive(ei), .internal_clk_stable(ist),
    .external_clk_stable(est), .slow_external_option(slow),
    .corr_valid(cv), .corr_up(cu), .err_large(el), .ring_tick(rt),
    .internal_gen_on(ion), .external_gen_on(eon), .osc_sel_external(osel),
    .timebase_sel_external(tsel), .monitor_irq(mirq), .irq(irq), .stage_code(stg),
    .divider_code(dv), .ring_stages(rs), .cycle_delays(cd), .long_cycle(lng)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic tally_and_finish;
    if (fail_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one classic cycle; ack and read data taken at the rising edge, request released there
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, sel, dat} <= {2'h3, w, a, 4'hf, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dato;
    {cyc, stb, we} <= 3'h0;
    if (n >= 20) chk("ack", 32'h0, 32'h1);
  endtask

  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask

  // one correction, then one ring tick with the new codes
  task automatic step(input logic up, input logic big);
    @(posedge clk);
    {cv, cu, el} <= {1'b1, up, big};
    @(posedge clk);
    {cv, rt} <= 2'h1;
    @(posedge clk);
    rt <= 1'b0;
    @(negedge clk);
  endtask

  task automatic s_reset;
    chk("outs", {ion, eon, osel, tsel, mirq, irq}, 6'h20);
    chk("codes", {stg, dv}, 12'h000);
    chk("period", {rs, cd}, {6'h11, 16'h0011});
    rc("ctrl", CMDS_ADDR_CTRL, 32'h01);
    wb(1'b1, 8'h20, 32'hff);
    rc("unmapped", 8'h20, 32'h0);
    rc("irq_clr", CMDS_ADDR_IRQ_CLR, 32'h0);
    rc("irq_en", CMDS_ADDR_IRQ_EN, 32'h0);
  endtask

  // the same write repeated sets the bits in order once conditions allow
  task automatic s_enable;
    slow <= 1'b1;
    wb(1'b1, CMDS_ADDR_CTRL, 32'ha5);
    rc("ctrl", CMDS_ADDR_CTRL, 32'h05);
    wb(1'b1, CMDS_ADDR_CTRL, 32'ha5);
    rc("ctrl", CMDS_ADDR_CTRL, 32'h05);
    {ist, est} <= 2'h3;
    wb(1'b1, CMDS_ADDR_CTRL, 32'ha5);
    rc("ctrl", CMDS_ADDR_CTRL, 32'h2f);
    wb(1'b1, CMDS_ADDR_CTRL, 32'ha5);
    rc("ctrl", CMDS_ADDR_CTRL, 32'haf);
    ist <= 1'b0;
    rc("ctrl", CMDS_ADDR_CTRL, 32'had);
    ist <= 1'b1;
    chk("gens", {ion, eon, osel}, 3'h6);
  endtask

  task automatic s_fail;
    wb(1'b1, CMDS_ADDR_IRQ_EN, 32'h1);
    ii <= 1'b1;
    repeat (3) @(posedge clk);
    ii <= 1'b0;
    @(negedge clk);
    chk("failover", {osel, tsel, mirq, irq}, 4'hf);
    wb(1'b1, CMDS_ADDR_CTRL, 32'hff);
    wb(1'b1, CMDS_ADDR_CTRL, 32'hbf);
    rc("ctrl", CMDS_ADDR_CTRL, 32'hff);
    wb(1'b1, CMDS_ADDR_CTRL, 32'hbf);
    rc("ctrl", CMDS_ADDR_CTRL, 32'hbf);
    chk("irqs", {mirq, irq}, 2'h1);
    wb(1'b1, CMDS_ADDR_IRQ_EN, 32'h0);
    @(negedge clk);
    chk("masked", irq, 1'b0);
    wb(1'b1, CMDS_ADDR_IRQ_EN, 32'h1);
    @(negedge clk);
    chk("unmasked", irq, 1'b1);
    rc("stat", CMDS_ADDR_IRQ_STAT, 32'h1);
    wb(1'b1, CMDS_ADDR_IRQ_CLR, 32'h1);
    @(negedge clk);
    chk("cleared", irq, 1'b0);
    wb(1'b1, CMDS_ADDR_CTRL, 32'h1f);
    rc("ctrl", CMDS_ADDR_CTRL, 32'h1f);
  endtask

  // coarse steps up through every ring length and divider code, then saturate
  task automatic s_step;
    for (int n = 1; n < 80; n++) begin
      step(1'b1, 1'b1);
      chk("codes", {stg, dv}, {8'((n % 8) * 32), 4'(n / 8)});
      chk("ring", rs, 6'(17 + 2 * (n % 8)));
      chk("delays", cd, 16'((17 + 2 * (n % 8)) << (n / 8)));
    end
    step(1'b1, 1'b1);
    chk("sat", {stg, dv}, 12'hff9);
    rc("dco", CMDS_ADDR_DCO, 32'h39ff);
    rc("stat", CMDS_ADDR_IRQ_STAT, 32'h6);
    wb(1'b1, CMDS_ADDR_IRQ_CLR, 32'h6);
    rc("stat", CMDS_ADDR_IRQ_STAT, 32'h0);
  endtask

  task automatic s_fine;
    int cnt;
    int sum;
    cnt = 0;
    sum = 0;
    step(1'b0, 1'b0);
    chk("fine", {stg, dv}, 12'hfe9);
    @(posedge clk);
    rt <= 1'b1;
    repeat (32) begin
      @(posedge clk);
      @(negedge clk);
      if (lng === 1'b1) cnt++;
      sum += rs;
    end
    @(posedge clk);
    rt <= 1'b0;
    chk("longs", cnt, 30);
    chk("stages", sum, 30 * 34 + 2 * 31);
    repeat (8) step(1'b0, 1'b1);
    chk("borrow", {stg, dv}, 12'hfe8);
    chk("halved", cd, {2'h0, rs, 8'h00});
    step(1'b1, 1'b0);
    chk("fine_up", {stg, dv}, 12'hff8);
  endtask

  initial begin
    {rst, cyc, stb, we, ii, ei, ist, est, slow, cv, cu, el, rt} = 13'h1000;
    {adr, sel, dat} = 44'h0;
    fail_count = 0;
    comparisons = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    s_reset;
    s_enable;
    s_fail;
    s_step;
    s_fine;
    tally_and_finish;
  end

  // the directed run needs under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    tally_and_finish;
  end
endmodule
